/* File: hdl/hie_pkg.sv */
// Constants and carrier types for the host interrupt enable block
package hie_pkg;

	// Register byte offsets
	localparam logic [7:0] HIE_OFS_STATUS     = 8'h58;
	localparam logic [7:0] HIE_OFS_ENABLE     = 8'h5c;
	localparam logic [7:0] HIE_OFS_THRESHOLDS = 8'h68;

	// Enable and status bit positions
	localparam int HIE_BIT_SOFTWARE      = 31;
	localparam int HIE_BIT_READY         = 30;
	localparam int HIE_BIT_TIMESTAMP     = 29;
	localparam int HIE_BIT_SWITCH        = 28;
	localparam int HIE_BIT_PHY_TWO       = 27;
	localparam int HIE_BIT_PHY_ONE       = 26;
	localparam int HIE_BIT_TX_STOPPED    = 25;
	localparam int HIE_BIT_RX_STOPPED    = 24;
	localparam int HIE_BIT_DROP_HALFWAY  = 23;
	localparam int HIE_BIT_TX_COMPLETION = 21;
	localparam int HIE_BIT_RX_DMA_DONE   = 20;
	localparam int HIE_BIT_GEN_TIMER     = 19;
	localparam int HIE_BIT_POWER_EVENT   = 17;
	localparam int HIE_BIT_TX_STS_OVFL   = 16;
	localparam int HIE_BIT_RX_WATCHDOG   = 15;
	localparam int HIE_BIT_RX_FAULT      = 14;
	localparam int HIE_BIT_TX_FAULT      = 13;
	localparam int HIE_BIT_GPIO_EVENT    = 12;
	localparam int HIE_BIT_SPARE_HIGH    = 11;
	localparam int HIE_BIT_TX_OVERRUN    = 10;
	localparam int HIE_BIT_TX_SPACE      = 9;
	localparam int HIE_BIT_TX_STS_FULL   = 8;
	localparam int HIE_BIT_TX_STS_LEVEL  = 7;
	localparam int HIE_BIT_RX_DROPPED    = 6;
	localparam int HIE_BIT_SPARE_LOW     = 5;
	localparam int HIE_BIT_RX_STS_FULL   = 4;
	localparam int HIE_BIT_RX_STS_LEVEL  = 3;

	// Threshold field positions, each field eight bits wide
	localparam int HIE_THR_W           = 8;
	localparam int HIE_THR_TX_SPACE_LSB = 24;
	localparam int HIE_THR_TX_STS_LSB   = 16;
	localparam int HIE_THR_RX_STS_LSB   = 0;

	// Reset values
	localparam logic [31:0] HIE_RST_ENABLE     = 32'h0000_0000;
	localparam logic [31:0] HIE_RST_STATUS     = 32'h0000_0000;
	localparam logic [31:0] HIE_RST_THRESHOLDS = 32'h4800_0000;

	// Register write strobe and data from the host bus interface
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} hie_reg_req_t;

	// Read answer
	typedef struct packed {
		logic        valid;
		logic [31:0] rdata;
	} hie_reg_rsp_t;

endpackage : hie_pkg

/* File: hdl/hie_level_flag.sv */
// Registered comparison of a FIFO level against a threshold
`timescale 1ns/1ps
module hie_level_flag #(
	parameter int LEVEL_W = 8,
	parameter int THR_W   = 8
) (
	// Clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_b_in,
	// Level and threshold
	input  wire logic [LEVEL_W-1:0] level_in,
	input  wire logic [THR_W-1:0]   threshold_in,
	// Level strictly above threshold
	output logic                    above_out
);

	initial begin
		if (LEVEL_W < THR_W) begin
			$error("hie_level_flag: LEVEL_W must cover the threshold width");
		end
	end

	logic [LEVEL_W-1:0] threshold_wide;

	assign threshold_wide = LEVEL_W'(threshold_in);

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			above_out <= 1'b0;
		end else begin
			above_out <= level_in > threshold_wide;
		end
	end

endmodule : hie_level_flag

/* File: hdl/hie_irq_ctrl.sv */
// Host interrupt enable mask, status flags and FIFO level thresholds
//
// Contract
// [R1] Sources reach the interrupt only when enabled
// [R2] Status sets regardless of enable, except software
// [R3] Enable bits 31 down to 24 placed
// [R4] Enable bits 23, 21, 20, 19 placed
// [R5] Enable bits 17 down to 12 placed
// [R6] Enable bits 10, 9, 8, 7, 6, 4, 3 placed
// [R7] Host writes zero to enable bits 11, 5
// [R8] TX space flag when free blocks exceed threshold
// [R9] TX status flag when occupancy exceeds threshold
// [R10] RX status flag when occupancy exceeds threshold
// [R11] Host keeps threshold bits 15:8 zero
// [R12] Interrupt follows any enabled set flag
// [R13] Enables reset zero; bits 22,18,2:0 read-only
`timescale 1ns/1ps
module hie_irq_ctrl
	import hie_pkg::*;
#(
	parameter int LEVEL_W = 8
) (
	// Clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_b_in,
	// Register port
	input  wire hie_reg_req_t       reg_req_in,
	input  wire logic               reg_rd_in,
	output hie_reg_rsp_t            reg_rsp_out,
	// Event pulses, one per status position
	input  wire logic [31:0]        event_pulse_in,
	// FIFO levels
	input  wire logic [LEVEL_W-1:0] tx_data_free_blocks_in,
	input  wire logic [LEVEL_W-1:0] tx_status_used_in,
	input  wire logic [LEVEL_W-1:0] rx_status_used_in,
	// Interrupt request, active high
	output logic                    irq_out
);

	initial begin
		if (LEVEL_W < HIE_THR_W || LEVEL_W > 16) begin
			$error("hie_irq_ctrl: LEVEL_W out of range");
		end
	end

	// Writable enable positions: every position except 22, 18 and 2:0
	localparam logic [31:0] ENABLE_WRITABLE =
		(32'h1 << HIE_BIT_SOFTWARE)      |
		(32'h1 << HIE_BIT_READY)         |
		(32'h1 << HIE_BIT_TIMESTAMP)     |
		(32'h1 << HIE_BIT_SWITCH)        |
		(32'h1 << HIE_BIT_PHY_TWO)       |
		(32'h1 << HIE_BIT_PHY_ONE)       |
		(32'h1 << HIE_BIT_TX_STOPPED)    |
		(32'h1 << HIE_BIT_RX_STOPPED)    | // [R3]
		(32'h1 << HIE_BIT_DROP_HALFWAY)  |
		(32'h1 << HIE_BIT_TX_COMPLETION) |
		(32'h1 << HIE_BIT_RX_DMA_DONE)   |
		(32'h1 << HIE_BIT_GEN_TIMER)     | // [R4]
		(32'h1 << HIE_BIT_POWER_EVENT)   |
		(32'h1 << HIE_BIT_TX_STS_OVFL)   |
		(32'h1 << HIE_BIT_RX_WATCHDOG)   |
		(32'h1 << HIE_BIT_RX_FAULT)      |
		(32'h1 << HIE_BIT_TX_FAULT)      |
		(32'h1 << HIE_BIT_GPIO_EVENT)    | // [R5]
		(32'h1 << HIE_BIT_SPARE_HIGH)    |
		(32'h1 << HIE_BIT_TX_OVERRUN)    |
		(32'h1 << HIE_BIT_TX_SPACE)      |
		(32'h1 << HIE_BIT_TX_STS_FULL)   |
		(32'h1 << HIE_BIT_TX_STS_LEVEL)  |
		(32'h1 << HIE_BIT_RX_DROPPED)    |
		(32'h1 << HIE_BIT_SPARE_LOW)     |
		(32'h1 << HIE_BIT_RX_STS_FULL)   |
		(32'h1 << HIE_BIT_RX_STS_LEVEL);   // [R6]

	// Status positions that hold a flag; spare enables have none
	localparam logic [31:0] STATUS_IMPL = ENABLE_WRITABLE &
		~(32'h1 << HIE_BIT_SPARE_HIGH) &
		~(32'h1 << HIE_BIT_SPARE_LOW);

	// Flags driven by the level comparators, not by event pulses
	localparam logic [31:0] LEVEL_FLAGS =
		(32'h1 << HIE_BIT_TX_SPACE)     |
		(32'h1 << HIE_BIT_TX_STS_LEVEL) |
		(32'h1 << HIE_BIT_RX_STS_LEVEL);

	// Software flag has no outside source
	localparam logic [31:0] PULSE_FLAGS = STATUS_IMPL & ~LEVEL_FLAGS &
		~(32'h1 << HIE_BIT_SOFTWARE);

	logic [31:0] enable_q;
	logic [31:0] enable_d;
	logic [31:0] status_q;
	logic [31:0] status_d;
	logic [31:0] thresholds_q;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic        wr_enable;
	logic        wr_status;
	logic        wr_thresholds;
	logic        sw_request;
	logic        tx_space_above;
	logic        tx_status_above;
	logic        rx_status_above;

	// Write decode
	assign wr_enable     = reg_req_in.sel && reg_req_in.wr &&
		reg_req_in.addr == HIE_OFS_ENABLE;
	assign wr_status     = reg_req_in.sel && reg_req_in.wr &&
		reg_req_in.addr == HIE_OFS_STATUS;
	assign wr_thresholds = reg_req_in.sel && reg_req_in.wr &&
		reg_req_in.addr == HIE_OFS_THRESHOLDS;

	// Enable register: read-only positions keep their zero
	always_comb begin
		enable_d = enable_q;
		if (wr_enable) begin
			enable_d = reg_req_in.wdata & ENABLE_WRITABLE; // [R13]
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			enable_q <= HIE_RST_ENABLE; // [R13]
		end else begin
			enable_q <= enable_d;
		end
	end

	// Threshold register, stored as written
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			thresholds_q <= HIE_RST_THRESHOLDS;
		end else if (wr_thresholds) begin
			thresholds_q <= reg_req_in.wdata;
		end
	end

	// Level comparators
	hie_level_flag #(
		.LEVEL_W (LEVEL_W),
		.THR_W   (HIE_THR_W)
	) u_tx_space (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.level_in     (tx_data_free_blocks_in),
		.threshold_in (thresholds_q[HIE_THR_TX_SPACE_LSB +: HIE_THR_W]),
		.above_out    (tx_space_above)
	); // [R8]

	hie_level_flag #(
		.LEVEL_W (LEVEL_W),
		.THR_W   (HIE_THR_W)
	) u_tx_status (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.level_in     (tx_status_used_in),
		.threshold_in (thresholds_q[HIE_THR_TX_STS_LSB +: HIE_THR_W]),
		.above_out    (tx_status_above)
	); // [R9]

	hie_level_flag #(
		.LEVEL_W (LEVEL_W),
		.THR_W   (HIE_THR_W)
	) u_rx_status (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.level_in     (rx_status_used_in),
		.threshold_in (thresholds_q[HIE_THR_RX_STS_LSB +: HIE_THR_W]),
		.above_out    (rx_status_above)
	); // [R10]

	// Software flag raised by writing its enable as one
	assign sw_request = wr_enable && reg_req_in.wdata[HIE_BIT_SOFTWARE];

	// Set sources: events are taken whatever the enables hold
	always_comb begin
		set_vec = event_pulse_in & PULSE_FLAGS; // [R2]
		set_vec[HIE_BIT_TX_SPACE]     = tx_space_above;  // [R8]
		set_vec[HIE_BIT_TX_STS_LEVEL] = tx_status_above; // [R9]
		set_vec[HIE_BIT_RX_STS_LEVEL] = rx_status_above; // [R10]
		set_vec[HIE_BIT_SOFTWARE]     = sw_request;      // [R2]
	end

	// Write one to clear; a set in the same cycle wins
	assign clr_vec = wr_status ? reg_req_in.wdata : 32'h0000_0000;

	always_comb begin
		status_d = ((status_q & ~clr_vec) | set_vec) & STATUS_IMPL;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			status_q <= HIE_RST_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	// Interrupt request from enabled flags only
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status_q & enable_q); // [R1] [R12]
		end
	end

	// Read answer one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			reg_rsp_out <= '0;
		end else begin
			reg_rsp_out.valid <= reg_req_in.sel && reg_rd_in;
			if (reg_req_in.sel && reg_rd_in) begin
				unique case (reg_req_in.addr)
					HIE_OFS_ENABLE:     reg_rsp_out.rdata <= enable_q;
					HIE_OFS_STATUS:     reg_rsp_out.rdata <= status_q;
					HIE_OFS_THRESHOLDS: reg_rsp_out.rdata <= thresholds_q;
					default:            reg_rsp_out.rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule : hie_irq_ctrl

/* File: verif/hie_irq_ctrl_properties.sv */
// Port-level checker for the interrupt enable and threshold block
`timescale 1ns/1ps
module hie_irq_ctrl_properties
	import hie_pkg::*;
#(
	parameter int LEVEL_W = 8
) (
	// Clock and reset
	input wire logic               clk_in,
	input wire logic               rst_b_in,
	// Register port
	input wire hie_reg_req_t       reg_req_in,
	input wire logic               reg_rd_in,
	input wire hie_reg_rsp_t       reg_rsp_out,
	// Events, levels and interrupt
	input wire logic [31:0]        event_pulse_in,
	input wire logic [LEVEL_W-1:0] tx_data_free_blocks_in,
	input wire logic [LEVEL_W-1:0] tx_status_used_in,
	input wire logic [LEVEL_W-1:0] rx_status_used_in,
	input wire logic               irq_out
);
	logic        wr_e;
	logic        rd_e;
	logic [7:0]  a;
	logic [31:0] en_q;
	logic [31:0] thr_q;
	assign wr_e = reg_req_in.sel & reg_req_in.wr;
	assign rd_e = reg_req_in.sel & reg_rd_in;
	assign a    = reg_req_in.addr;
	// Shadow copies of the writable registers
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			en_q  <= 32'h0000_0000;
			thr_q <= 32'h4800_0000;
		end else if (wr_e && a == HIE_OFS_ENABLE) begin
			en_q <= reg_req_in.wdata & 32'hffbb_fff8;
		end else if (wr_e && a == HIE_OFS_THRESHOLDS) begin
			thr_q <= reg_req_in.wdata;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	property p_rd_valid;
		rd_e |=> reg_rsp_out.valid;
	endproperty
	a_rd_valid: assert property (p_rd_valid)
		else $error("read not answered");
	property p_valid_cause;
		reg_rsp_out.valid |-> $past(rd_e);
	endproperty
	a_valid_cause: assert property (p_valid_cause)
		else $error("answer without read");
	property p_rd_hold;
		!rd_e |=> $stable(reg_rsp_out.rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved");
	property p_en_rd;
		rd_e && a == HIE_OFS_ENABLE |=> reg_rsp_out.rdata == $past(en_q);
	endproperty
	a_en_rd: assert property (p_en_rd)
		else $error("enable readback wrong");
	property p_thr_rd;
		rd_e && a == HIE_OFS_THRESHOLDS |=> reg_rsp_out.rdata == $past(thr_q);
	endproperty
	a_thr_rd: assert property (p_thr_rd)
		else $error("threshold readback wrong");
	property p_unmapped;
		rd_e && !(a inside {8'h58, 8'h5c, 8'h68}) |=> reg_rsp_out.rdata == 0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_irq_en;
		irq_out |-> $past(en_q) != 32'h0;
	endproperty
	a_irq_en: assert property (p_irq_en)
		else $error("interrupt with no enable");
	property p_sw_irq;
		wr_e && a == HIE_OFS_ENABLE && reg_req_in.wdata[31] |=> ##1 irq_out;
	endproperty
	a_sw_irq: assert property (p_sw_irq)
		else $error("software interrupt missing");
	property p_irq_drop;
		wr_e && a == HIE_OFS_ENABLE && reg_req_in.wdata == 0 |=> ##1 !irq_out;
	endproperty
	a_irq_drop: assert property (p_irq_drop)
		else $error("interrupt stayed after disable");
	c_sw: cover property (wr_e && a == HIE_OFS_ENABLE && reg_req_in.wdata[31]);
	c_irq: cover property ($rose(irq_out));
	c_unm: cover property (rd_e && a == 8'h60);
endmodule : hie_irq_ctrl_properties
bind hie_irq_ctrl hie_irq_ctrl_properties #(.LEVEL_W(LEVEL_W)) u_props (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_req_in(reg_req_in),
	.reg_rd_in(reg_rd_in), .reg_rsp_out(reg_rsp_out),
	.event_pulse_in(event_pulse_in),
	.tx_data_free_blocks_in(tx_data_free_blocks_in),
	.tx_status_used_in(tx_status_used_in),
	.rx_status_used_in(rx_status_used_in), .irq_out(irq_out));

/* File: verif/hie_host_model.sv */
// Host processor model driving the register port
`timescale 1ns/1ps
module hie_host_model
	import hie_pkg::*;
(
	input  wire logic         clk_in,
	input  wire hie_reg_rsp_t rsp_in,
	output hie_reg_req_t      req_out,
	output logic              rd_out
);
	initial begin
		req_out = '0;
		rd_out  = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		req_out <= '{1'b1, 1'b1, a, d & ((a == HIE_OFS_THRESHOLDS) ?
			32'hffff_00ff : 32'hffff_f7df)};
		@(posedge clk_in);
		req_out <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		req_out <= '{1'b1, 1'b0, a, 32'h0};
		rd_out  <= 1'b1;
		@(posedge clk_in);
		req_out <= '{1'b0, 1'b0, ~a, 32'hffff_ffff};
		rd_out  <= 1'b0;
		// Answer stands in the cycle after the taking edge
		@(posedge clk_in);
		d = rsp_in.valid ? rsp_in.rdata : 'x;
	endtask : rd
endmodule : hie_host_model

/* File: verif/hie_irq_ctrl_tb.sv */
// Self-checking bench for the interrupt enable and threshold block
`timescale 1ns/1ps
module hie_irq_ctrl_tb;
	import hie_pkg::*;
	logic         clk_in = 1'b0;
	logic         rst_b_in = 1'b0;
	logic [31:0]  ev = '0;
	logic [7:0]   txf = '0;
	logic [7:0]   txs = '0;
	logic [7:0]   rxs = '0;
	hie_reg_req_t req;
	logic         rd;
	hie_reg_rsp_t rsp;
	logic         irq;
	logic [31:0]  d;
	int           n_mismatch = 0;
	int           n_tests = 0;
	int           cyc = 0;
	int unsigned  evb[21] = '{30, 29, 28, 27, 26, 25, 24, 23, 21, 20, 19,
		17, 16, 15, 14, 13, 12, 10, 8, 6, 4};
	always #12.5 clk_in = ~clk_in;
	hie_host_model host (.clk_in(clk_in), .rsp_in(rsp), .req_out(req),
		.rd_out(rd));
	hie_irq_ctrl #(.LEVEL_W(8)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.reg_req_in(req), .reg_rd_in(rd), .reg_rsp_out(rsp),
		.event_pulse_in(ev), .tx_data_free_blocks_in(txf),
		.tx_status_used_in(txs), .rx_status_used_in(rxs), .irq_out(irq));
	task automatic summarize();
		$display("mismatches %0d checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string s, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, string s);
		host.rd(a, d);
		chk(s, d, e);
	endtask : rchk
	task automatic irqchk(input logic e);
		repeat (3) @(posedge clk_in);
		#1;
		chk("irq", {31'h0, irq}, {31'h0, e});
	endtask : irqchk
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rchk(HIE_OFS_ENABLE, 32'h0, "enable reset");
		rchk(HIE_OFS_THRESHOLDS, 32'h4800_0000, "thr reset");
		rchk(8'h60, 32'h0, "unmapped");
		host.wr(HIE_OFS_ENABLE, 32'hffff_ffff);
		irqchk(1'b1);
		rchk(HIE_OFS_ENABLE, 32'hffbb_f7d8, "enable");
		host.wr(HIE_OFS_ENABLE, 32'h0);
		irqchk(1'b0);
		rchk(HIE_OFS_STATUS, 32'h8000_0000, "sw status");
		host.wr(HIE_OFS_STATUS, 32'h8000_0000);
		// Every pulse at once: reserved, level and software bits stay clear
		@(posedge clk_in);
		ev <= 32'hffff_ffff;
		@(posedge clk_in);
		ev <= '0;
		irqchk(1'b0);
		rchk(HIE_OFS_STATUS, 32'h7fbb_f550, "all events");
		host.wr(HIE_OFS_STATUS, 32'hffff_ffff);
		// Each pulse source: sets status while masked, then drives the request
		foreach (evb[i]) begin
			@(posedge clk_in);
			ev <= 32'h1 << evb[i];
			@(posedge clk_in);
			ev <= '0;
			irqchk(1'b0);
			rchk(HIE_OFS_STATUS, 32'h1 << evb[i], "event status");
			host.wr(HIE_OFS_ENABLE, 32'h1 << evb[i]);
			irqchk(1'b1);
			host.wr(HIE_OFS_STATUS, 32'h1 << evb[i]);
			host.wr(HIE_OFS_ENABLE, 32'h0);
		end
		host.wr(HIE_OFS_THRESHOLDS, 32'h0510_ff03);
		rchk(HIE_OFS_THRESHOLDS, 32'h0510_0003, "thr");
		@(posedge clk_in);
		txf <= 8'h05;
		txs <= 8'h10;
		rxs <= 8'h03;
		repeat (3) @(posedge clk_in);
		rchk(HIE_OFS_STATUS, 32'h0, "level equal");
		txf <= 8'h06;
		txs <= 8'h11;
		rxs <= 8'h04;
		repeat (3) @(posedge clk_in);
		rchk(HIE_OFS_STATUS, 32'h0000_0288, "level above");
		host.wr(HIE_OFS_ENABLE, 32'h0000_0008);
		irqchk(1'b1);
		@(posedge clk_in);
		rxs <= 8'h03;
		repeat (2) @(posedge clk_in);
		host.wr(HIE_OFS_STATUS, 32'h0000_0008);
		irqchk(1'b0);
		summarize();
	end
endmodule : hie_irq_ctrl_tb
